/* File: rtl/prc_pkg.sv */
/*
  Constants shared by the pill reminder controller: timing, link command and
  message codes, payload field positions and record storage layout.
  Assumes a single 200 MHz system clock.
*/
package prc_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ            = 200000000;
  localparam int unsigned TONE_HZ           = 512;
  localparam int unsigned TONE_HALF_CYC_DEF = CLK_HZ / (2 * TONE_HZ);
  localparam int unsigned RADIO_RST_CYC_DEF = 16;
  localparam logic [5:0]  DISPLAY_S         = 6'h0a;
  localparam logic [5:0]  ALARM_WIN_S       = 6'h3c;
  localparam logic [5:0]  BEEP_PERIOD_S     = 6'h3c;
  localparam logic [5:0]  BEEP_LEN_S        = 6'h01;

  // ************************************************************
  // Battery
  // ************************************************************
  localparam logic [15:0] BATT_LOW_MV = 16'h09c4;

  // ************************************************************
  // Link commands, messages and payload fields
  // ************************************************************
  localparam logic [7:0] CMD_SET_ALARM  = 8'h01;
  localparam logic [7:0] CMD_RTC_CAL    = 8'h02;
  localparam logic [7:0] CMD_BATT_QUERY = 8'h03;
  localparam logic [7:0] MSG_RADIO_CFG  = 8'h10;
  localparam logic [7:0] MSG_PILL_TAKEN = 8'h11;
  localparam logic [7:0] MSG_BATT_VALUE = 8'h12;
  localparam int unsigned FLD_SEC  = 0;
  localparam int unsigned FLD_MIN  = 8;
  localparam int unsigned FLD_HOUR = 16;
  localparam int unsigned FLD_DAY  = 24;
  localparam int unsigned FLD_WDAY = 32;
  localparam int unsigned FLD_MON  = 40;
  localparam int unsigned FLD_YEAR = 48;
  localparam int unsigned AL_MIN   = 0;
  localparam int unsigned AL_HOUR  = 8;
  localparam int unsigned AL_WDAY  = 16;

  // ************************************************************
  // Record storage: 4 blocks of 256 three-byte records
  // ************************************************************
  localparam int unsigned REC_W      = 24;
  localparam int unsigned BLK_W      = 2;
  localparam int unsigned PTR_W      = 8;
  localparam int unsigned ADDR_W     = BLK_W + PTR_W;
  localparam logic [7:0]  LAST_IDX   = 8'hff;
  localparam logic [7:0]  COPY_BASE  = 8'hfd;
  localparam logic [7:0]  KEEP_RECS  = 8'h03;
  localparam logic [8:0]  COPY_LAST  = 9'h005;
  localparam logic [2:0]  WDAY_COUNT = 3'h7;

  typedef enum logic [3:0] {
    ST_INIT, ST_BATT_START, ST_BATT_WAIT, ST_IDLE, ST_NORMAL, ST_ALARM_SET,
    ST_RTC_CAL, ST_ALARM_PROC, ST_PILL_REC, ST_ADJ_COPY, ST_ADJ_ERASE
  } prc_state_e;

endpackage : prc_pkg

/* File: rtl/prc_key_sync.sv */
/*
  Key input synchroniser and falling edge detector.
  Assumes keys are active low pins asynchronous to the clock.
*/
`timescale 1ns/1ps
module prc_key_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] keys_n_i,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;
  logic [W-1:0] fall_q;
  logic [W-1:0] fall_d;

  always_comb
  begin
    fall_d = prev_q & ~sync_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
      fall_q <= '0;
    end
    else
    begin
      meta_q <= keys_n_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
      fall_q <= fall_d;
    end
  end

  assign fall_o = fall_q;

endmodule : prc_key_sync

/* File: rtl/prc_rec_store.sv */
/*
  Alarm record memory with one write port and a registered read port.
  Assumes the controller sequences copies and block erases itself.
*/
`timescale 1ns/1ps
module prc_rec_store #(
  parameter int unsigned AW = 10,
  parameter int unsigned DW = 24
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_q <= mem[raddr_i];
  end

  assign rdata_o = rdata_q;

endmodule : prc_rec_store

/* File: rtl/prc_top.sv */
/*
  Pill reminder controller: mode sequencer, alarm outputs, battery check,
  record storage housekeeping and message requests to the radio module.
  Assumes RTC events, ADC and link words come from logic on the same clock;
  key pins are asynchronous.
*/
`timescale 1ns/1ps
module prc_top
  import prc_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC   = CLK_HZ,
  parameter int unsigned TONE_HALF_CYC = TONE_HALF_CYC_DEF,
  parameter int unsigned RADIO_RST_CYC = RADIO_RST_CYC_DEF
) (
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  input  wire logic        WAKE_ACK_KEY_N_I,
  input  wire logic        CONFIG_KEY_N_I,
  input  wire logic        RADIO_POWER_KEY_N_I,
  input  wire logic        RTC_ALARM_I,
  input  wire logic        RTC_HOUR_I,
  input  wire logic [2:0]  RTC_WEEKDAY_I,
  input  wire logic        RX_VALID_I,
  input  wire logic [7:0]  RX_CMD_I,
  input  wire logic [55:0] RX_DATA_I,
  output logic             RX_READY_O,
  output logic             TX_VALID_O,
  input  wire logic        TX_READY_I,
  output logic      [7:0]  TX_MSG_O,
  output logic      [15:0] TX_DATA_O,
  output logic             ADC_START_O,
  input  wire logic        ADC_DONE_I,
  input  wire logic [15:0] ADC_DATA_I,
  output logic             BATT_DIV_EN_O,
  output logic             BATT_LOW_O,
  output logic             BUZZER_TONE_OUT_O,
  output logic             MOTOR_O,
  output logic      [6:0]  CELL_LAMP_O,
  output logic             DISPLAY_ON_O,
  output logic             IDLE_O,
  output logic             RADIO_SUPPLY_SWITCH_O,
  output logic             RADIO_RESET_O,
  output logic             ALARM_WRITE_O,
  output logic      [7:0]  ALARM_MINUTE_VALUE_O,
  output logic      [7:0]  ALARM_HOUR_VALUE_O,
  output logic      [7:0]  ALARM_WEEKDAY_VALUE_O,
  output logic             CAL_WRITE_O,
  output logic      [55:0] CAL_COUNTS_O
);

  // ************************************************************
  // Keys and record memory
  // ************************************************************
  logic [2:0]        key_fall;
  logic              wake_fall;
  logic              cfg_fall;
  logic              radio_fall;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [REC_W-1:0]  mem_wdata;
  logic [ADDR_W-1:0] mem_raddr;
  logic [REC_W-1:0]  mem_rdata;

  prc_key_sync #(.W(3)) u_keys (
    .clk_i    (CLK_I),
    .srst_i   (SRST_I),
    .keys_n_i ({RADIO_POWER_KEY_N_I, CONFIG_KEY_N_I, WAKE_ACK_KEY_N_I}),
    .fall_o   (key_fall)
  );

  assign wake_fall  = key_fall[0];
  assign cfg_fall   = key_fall[1];
  assign radio_fall = key_fall[2];

  prc_rec_store #(.AW(ADDR_W), .DW(REC_W)) u_store (
    .clk_i   (CLK_I),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (mem_wdata),
    .raddr_i (mem_raddr),
    .rdata_o (mem_rdata)
  );

  function automatic logic [6:0] wday_lamp(input logic [2:0] wd);
    wday_lamp = (wd < WDAY_COUNT) ? 7'(7'h01 << wd) : 7'h00;
  endfunction : wday_lamp

  // ************************************************************
  // Second tick
  // ************************************************************
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic        sec_tick;
  logic        tick_clr;

  always_comb
  begin
    sec_tick   = (tick_cnt_q == CYC_PER_SEC - 1);
    tick_cnt_d = (tick_clr || sec_tick) ? 32'h0 : tick_cnt_q + 32'h1;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      tick_cnt_q <= 32'h0;
    else
      tick_cnt_q <= tick_cnt_d;
  end

  // ************************************************************
  // Mode sequencer
  // ************************************************************
  prc_state_e        state_q, state_d;
  logic [5:0]        win_q, win_d;
  logic [31:0]       rst_cnt_q, rst_cnt_d;
  logic [8:0]        adj_cnt_q, adj_cnt_d;
  logic [BLK_W-1:0]  blk_q, blk_d;
  logic [PTR_W-1:0]  ptr_q, ptr_d;
  logic              al_pend_q, al_pend_d;
  logic              hr_pend_q, hr_pend_d;
  logic [6:0]        lamp_q, lamp_d;
  logic [23:0]       alarm_q, alarm_d;
  logic [55:0]       cal_q, cal_d;
  logic              al_wr_q, cal_wr_q;
  logic [15:0]       batt_q, batt_d;
  logic              low_q, low_d;
  logic              adc_q, div_q, disp_q, idle_q;
  logic              pill_req, batt_req, al_take, hr_take, any_event;

  always_comb
  begin
    state_d   = state_q;
    win_d     = win_q + {5'h00, sec_tick};
    rst_cnt_d = rst_cnt_q;
    adj_cnt_d = adj_cnt_q;
    blk_d     = blk_q;
    ptr_d     = ptr_q;
    lamp_d    = lamp_q;
    alarm_d   = alarm_q;
    cal_d     = cal_q;
    batt_d    = batt_q;
    low_d     = low_q;
    tick_clr  = 1'b0;
    pill_req  = 1'b0;
    batt_req  = 1'b0;
    al_take   = 1'b0;
    hr_take   = 1'b0;
    mem_we    = 1'b0;
    mem_waddr = {blk_q, ptr_q};
    mem_wdata = alarm_q;
    mem_raddr = {blk_q, COPY_BASE + {6'h00, adj_cnt_q[2:1]}};
    any_event = al_pend_q | hr_pend_q | RX_VALID_I | (|key_fall);
    unique case (state_q)
      ST_INIT:
      begin
        rst_cnt_d = rst_cnt_q + 32'h1;
        if (rst_cnt_q == RADIO_RST_CYC - 1)
          state_d = ST_BATT_START;
      end
      ST_BATT_START:
        state_d = ST_BATT_WAIT;
      ST_BATT_WAIT:
        if (ADC_DONE_I)
        begin
          batt_d  = ADC_DATA_I;
          low_d   = (ADC_DATA_I < BATT_LOW_MV);
          state_d = ST_NORMAL;
          win_d   = 6'h00;
          tick_clr = 1'b1;
        end
      ST_IDLE:
        if (any_event)
        begin
          state_d  = ST_NORMAL;
          win_d    = 6'h00;
          tick_clr = 1'b1;
        end
      ST_NORMAL:
      begin
        win_d    = win_q + {5'h00, sec_tick};
        if (al_pend_q)
        begin
          al_take  = 1'b1;
          lamp_d   = wday_lamp(RTC_WEEKDAY_I);
          state_d  = ST_ALARM_PROC;
          win_d    = 6'h00;
          tick_clr = 1'b1;
        end
        else if (RX_VALID_I)
        begin
          win_d    = 6'h00;
          tick_clr = 1'b1;
          if (RX_CMD_I == CMD_SET_ALARM)
          begin
            alarm_d = RX_DATA_I[23:0];
            state_d = ST_ALARM_SET;
          end
          else if (RX_CMD_I == CMD_RTC_CAL)
          begin
            cal_d   = RX_DATA_I;
            state_d = ST_RTC_CAL;
          end
          else if (RX_CMD_I == CMD_BATT_QUERY)
            batt_req = 1'b1;
        end
        else if (hr_pend_q)
        begin
          hr_take = 1'b1;
          state_d = ST_BATT_START;
        end
        else if (|key_fall)
        begin
          win_d    = 6'h00;
          tick_clr = 1'b1;
        end
        else if (win_q == DISPLAY_S)
          state_d = ST_IDLE;
      end
      ST_ALARM_SET:
      begin
        mem_we = 1'b1;
        if (ptr_q == LAST_IDX)
        begin
          adj_cnt_d = 9'h000;
          state_d   = ST_ADJ_COPY;
        end
        else
        begin
          ptr_d   = ptr_q + 8'h01;
          state_d = ST_NORMAL;
        end
      end
      ST_ADJ_COPY:
      begin
        mem_waddr = {blk_q + 2'h1, 6'h00, adj_cnt_q[2:1]};
        mem_wdata = mem_rdata;
        mem_we    = adj_cnt_q[0];
        adj_cnt_d = adj_cnt_q + 9'h001;
        if (adj_cnt_q == COPY_LAST)
        begin
          adj_cnt_d = 9'h000;
          state_d   = ST_ADJ_ERASE;
        end
      end
      ST_ADJ_ERASE:
      begin
        mem_waddr = {blk_q, adj_cnt_q[7:0]};
        mem_wdata = '0;
        mem_we    = 1'b1;
        adj_cnt_d = adj_cnt_q + 9'h001;
        if (adj_cnt_q[7:0] == LAST_IDX)
        begin
          blk_d    = blk_q + 2'h1;
          ptr_d    = KEEP_RECS;
          state_d  = ST_NORMAL;
          win_d    = 6'h00;
          tick_clr = 1'b1;
        end
      end
      ST_RTC_CAL:
        state_d = ST_NORMAL;
      ST_ALARM_PROC:
        if (wake_fall)
        begin
          lamp_d  = 7'h00;
          state_d = ST_PILL_REC;
        end
        else if (win_q == ALARM_WIN_S)
        begin
          lamp_d   = 7'h00;
          state_d  = ST_NORMAL;
          win_d    = 6'h00;
          tick_clr = 1'b1;
        end
      ST_PILL_REC:
      begin
        pill_req = 1'b1;
        state_d  = ST_NORMAL;
        win_d    = 6'h00;
        tick_clr = 1'b1;
      end
      default:
        state_d = ST_INIT;
    endcase
    al_pend_d = (al_pend_q & ~al_take) | RTC_ALARM_I;
    hr_pend_d = (hr_pend_q & ~hr_take) | RTC_HOUR_I;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      state_q   <= ST_INIT;
      win_q     <= 6'h00;
      rst_cnt_q <= 32'h0;
      adj_cnt_q <= 9'h000;
      blk_q     <= '0;
      ptr_q     <= '0;
      al_pend_q <= 1'b0;
      hr_pend_q <= 1'b0;
      lamp_q    <= 7'h00;
      alarm_q   <= 24'h000000;
      cal_q     <= 56'h0;
      al_wr_q   <= 1'b0;
      cal_wr_q  <= 1'b0;
      batt_q    <= 16'h0000;
      low_q     <= 1'b0;
      adc_q     <= 1'b0;
      div_q     <= 1'b0;
      disp_q    <= 1'b1;
      idle_q    <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      win_q     <= win_d;
      rst_cnt_q <= rst_cnt_d;
      adj_cnt_q <= adj_cnt_d;
      blk_q     <= blk_d;
      ptr_q     <= ptr_d;
      al_pend_q <= al_pend_d;
      hr_pend_q <= hr_pend_d;
      lamp_q    <= lamp_d;
      alarm_q   <= alarm_d;
      cal_q     <= cal_d;
      al_wr_q   <= (state_q == ST_ALARM_SET);
      cal_wr_q  <= (state_q == ST_RTC_CAL);
      batt_q    <= batt_d;
      low_q     <= low_d;
      adc_q     <= (state_d == ST_BATT_START);
      div_q     <= (state_d == ST_BATT_START) || (state_d == ST_BATT_WAIT);
      disp_q    <= (state_d != ST_IDLE);
      idle_q    <= (state_d == ST_IDLE);
    end
  end

  // ************************************************************
  // Tone, low battery beep and radio supply
  // ************************************************************
  logic [31:0] tone_cnt_q, tone_cnt_d;
  logic        tone_q, tone_d;
  logic [5:0]  beep_s_q, beep_s_d;
  logic        radio_q, radio_d;
  logic        motor_q, motor_d;
  logic        tone_on;

  always_comb
  begin
    beep_s_d = beep_s_q;
    if (!low_q)
      beep_s_d = 6'h00;
    else if (sec_tick)
      beep_s_d = (beep_s_q == BEEP_PERIOD_S - 6'h01) ? 6'h00 : beep_s_q + 6'h01;
    tone_on    = (state_q == ST_ALARM_PROC) || (low_q && (beep_s_q < BEEP_LEN_S));
    tone_cnt_d = 32'h0;
    tone_d     = 1'b0;
    if (tone_on)
    begin
      tone_cnt_d = (tone_cnt_q == TONE_HALF_CYC - 1) ? 32'h0 : tone_cnt_q + 32'h1;
      tone_d     = (tone_cnt_q == TONE_HALF_CYC - 1) ? ~tone_q : tone_q;
    end
    motor_d = (state_d == ST_ALARM_PROC);
    radio_d = radio_q ^ radio_fall;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      tone_cnt_q <= 32'h0;
      tone_q     <= 1'b0;
      beep_s_q   <= 6'h00;
      radio_q    <= 1'b1;
      motor_q    <= 1'b0;
    end
    else
    begin
      tone_cnt_q <= tone_cnt_d;
      tone_q     <= tone_d;
      beep_s_q   <= beep_s_d;
      radio_q    <= radio_d;
      motor_q    <= motor_d;
    end
  end

  // ************************************************************
  // Outgoing messages
  // ************************************************************
  logic        pill_p_q, pill_p_d, batt_p_q, batt_p_d, cfg_p_q, cfg_p_d;
  logic        txv_q, txv_d;
  logic [7:0]  txm_q, txm_d;
  logic [15:0] txd_q, txd_d;
  logic        free, g_pill, g_batt, g_cfg;

  always_comb
  begin
    free   = !txv_q || TX_READY_I;
    g_pill = free && pill_p_q;
    g_batt = free && !pill_p_q && batt_p_q;
    g_cfg  = free && !pill_p_q && !batt_p_q && cfg_p_q;
    txv_d  = txv_q && !TX_READY_I;
    txm_d  = txm_q;
    txd_d  = txd_q;
    if (g_pill)
    begin
      txv_d = 1'b1;
      txm_d = MSG_PILL_TAKEN;
      txd_d = 16'h0000;
    end
    else if (g_batt)
    begin
      txv_d = 1'b1;
      txm_d = MSG_BATT_VALUE;
      txd_d = batt_q;
    end
    else if (g_cfg)
    begin
      txv_d = 1'b1;
      txm_d = MSG_RADIO_CFG;
      txd_d = 16'h0000;
    end
    pill_p_d = (pill_p_q & ~g_pill) | pill_req;
    batt_p_d = (batt_p_q & ~g_batt) | batt_req;
    cfg_p_d  = (cfg_p_q & ~g_cfg) | cfg_fall;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      pill_p_q <= 1'b0;
      batt_p_q <= 1'b0;
      cfg_p_q  <= 1'b0;
      txv_q    <= 1'b0;
      txm_q    <= 8'h00;
      txd_q    <= 16'h0000;
    end
    else
    begin
      pill_p_q <= pill_p_d;
      batt_p_q <= batt_p_d;
      cfg_p_q  <= cfg_p_d;
      txv_q    <= txv_d;
      txm_q    <= txm_d;
      txd_q    <= txd_d;
    end
  end

  // ************************************************************
  // Output drive
  // ************************************************************
  assign RX_READY_O            = (state_q == ST_NORMAL) && !al_pend_q;
  assign TX_VALID_O            = txv_q;
  assign TX_MSG_O              = txm_q;
  assign TX_DATA_O             = txd_q;
  assign ADC_START_O           = adc_q;
  assign BATT_DIV_EN_O         = div_q;
  assign BATT_LOW_O            = low_q;
  assign BUZZER_TONE_OUT_O     = tone_q;
  assign MOTOR_O               = motor_q;
  assign CELL_LAMP_O           = lamp_q;
  assign DISPLAY_ON_O          = disp_q;
  assign IDLE_O                = idle_q;
  assign RADIO_SUPPLY_SWITCH_O = radio_q;
  assign RADIO_RESET_O         = (state_q == ST_INIT);
  assign ALARM_WRITE_O         = al_wr_q;
  assign ALARM_MINUTE_VALUE_O  = alarm_q[AL_MIN +: 8];
  assign ALARM_HOUR_VALUE_O    = alarm_q[AL_HOUR +: 8];
  assign ALARM_WEEKDAY_VALUE_O = alarm_q[AL_WDAY +: 8];
  assign CAL_WRITE_O           = cal_wr_q;
  assign CAL_COUNTS_O          = cal_q;

endmodule : prc_top

/* File: verification/prc_top_properties.sv */
/*
  Port checker for prc_top, attached by bind.
  Assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
module prc_top_properties
  import prc_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        SRST_I,
  input wire logic [2:0]  RTC_WEEKDAY_I,
  input wire logic        RX_VALID_I,
  input wire logic [7:0]  RX_CMD_I,
  input wire logic [55:0] RX_DATA_I,
  input wire logic        RX_READY_O,
  input wire logic        TX_VALID_O,
  input wire logic        TX_READY_I,
  input wire logic [7:0]  TX_MSG_O,
  input wire logic [15:0] TX_DATA_O,
  input wire logic        ADC_START_O,
  input wire logic        BATT_DIV_EN_O,
  input wire logic        BUZZER_TONE_OUT_O,
  input wire logic        MOTOR_O,
  input wire logic [6:0]  CELL_LAMP_O,
  input wire logic        DISPLAY_ON_O,
  input wire logic        IDLE_O,
  input wire logic        ALARM_WRITE_O,
  input wire logic [7:0]  ALARM_MINUTE_VALUE_O,
  input wire logic [7:0]  ALARM_HOUR_VALUE_O,
  input wire logic [7:0]  ALARM_WEEKDAY_VALUE_O,
  input wire logic        CAL_WRITE_O,
  input wire logic [55:0] CAL_COUNTS_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  adc_div_a: assert property (ADC_START_O |-> BATT_DIV_EN_O)
    else $error("converter started with divider off");
  disp_idle_a: assert property (DISPLAY_ON_O == !IDLE_O)
    else $error("display state does not match idle");
  ready_mode_a: assert property (RX_READY_O |-> !IDLE_O && !MOTOR_O && !BATT_DIV_EN_O)
    else $error("link ready outside normal mode");
  lamp_day_a: assert property (MOTOR_O && RTC_WEEKDAY_I != 3'h7
    |-> CELL_LAMP_O == 7'h01 << RTC_WEEKDAY_I) else $error("wrong weekday lamp");
  lamp_off_a: assert property (!MOTOR_O |-> CELL_LAMP_O == 7'h00)
    else $error("lamp lit outside alarm");
  tone_half_a: assert property (MOTOR_O && $rose(BUZZER_TONE_OUT_O) ##1 MOTOR_O[*4]
    |-> !BUZZER_TONE_OUT_O && $past(BUZZER_TONE_OUT_O, 3)) else $error("tone half period");
  al_write_a: assert property (RX_VALID_I && RX_READY_O && RX_CMD_I == CMD_SET_ALARM
    |-> ##2 ALARM_WRITE_O && 56'({ALARM_WEEKDAY_VALUE_O, ALARM_HOUR_VALUE_O,
    ALARM_MINUTE_VALUE_O}) == ($past(RX_DATA_I, 2) & 56'hff_ffff)) else $error("alarm write");
  cal_write_a: assert property (RX_VALID_I && RX_READY_O && RX_CMD_I == CMD_RTC_CAL
    |-> ##2 CAL_WRITE_O && CAL_COUNTS_O == $past(RX_DATA_I, 2)) else $error("cal write");
  tx_hold_a: assert property (TX_VALID_O && !TX_READY_I
    |=> TX_VALID_O && $stable(TX_MSG_O) && $stable(TX_DATA_O)) else $error("message dropped");
endmodule : prc_top_properties

/* File: verification/prc_radio_model.sv */
/*
  Radio module model: sends link commands, takes messages with optional stalls.
  Assumes the bench calls send at a falling edge.
*/
`timescale 1ns/1ps
module prc_radio_model (
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  input  wire logic        rx_ready_i,
  output logic             rx_valid_o,
  output logic      [7:0]  rx_cmd_o,
  output logic      [55:0] rx_data_o,
  input  wire logic        tx_valid_i,
  input  wire logic [7:0]  tx_msg_i,
  input  wire logic [15:0] tx_data_i,
  output logic             tx_ready_o
);
  logic [7:0]  last_msg = 8'h00;
  logic [15:0] last_data = 16'h0000;
  logic [1:0]  stall_q = 2'h0;
  int          msg_count = 0;

  initial
  begin
    rx_valid_o = 1'b0;
    rx_cmd_o = 8'h00;
    rx_data_o = 56'h0;
    tx_ready_o = 1'b1;
  end

  always @(negedge clk_i)
  begin
    stall_q <= stall_q + 2'h1;
    tx_ready_o <= !slow_i || stall_q == 2'h3;
  end

  always @(posedge clk_i)
    if (tx_valid_i && tx_ready_o)
    begin
      last_msg <= tx_msg_i;
      last_data <= tx_data_i;
      msg_count <= msg_count + 1;
    end

  // Lets an edge pass, holds the command until taken, then scrambles the lines
  task automatic send(input logic [7:0] c, input logic [55:0] d, output int n);
    @(negedge clk_i);
    rx_cmd_o = c;
    rx_data_o = d;
    rx_valid_o = 1'b1;
    for (n = 0; n < 400; n++)
    begin
      if (rx_ready_i) break;
      @(negedge clk_i);
    end
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_cmd_o = ~c;
    rx_data_o = ~d;
  endtask : send
endmodule : prc_radio_model

/* File: verification/prc_top_tb_top.sv */
/*
  Bench for prc_top with the radio model and a converter responder.
  Assumes one second is 20 cycles and a 4 cycle tone half period.
*/
`timescale 1ns/1ps
module prc_top_tb_top;
  import prc_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, alarm = 1'b0, hour = 1'b0, slow = 1'b0;
  logic        adc_done = 1'b0, prev;
  logic [2:0]  keys_n = 3'h7, wday = 3'h0;
  logic [15:0] adc_mv = 16'h0bb8;
  logic [7:0]  rx_c, tx_m;
  logic [55:0] rx_d;
  logic [15:0] tx_d;
  logic        rx_v, rx_r, tx_v, tx_r;
  int          errors = 0, check_count = 0, adc_cnt = 0, n, i, t, mc;

  always #2.5 clk = ~clk;

  prc_top #(.CYC_PER_SEC(20), .TONE_HALF_CYC(4), .RADIO_RST_CYC(2)) uut (
    .CLK_I(clk), .SRST_I(srst), .WAKE_ACK_KEY_N_I(keys_n[0]), .CONFIG_KEY_N_I(keys_n[1]),
    .RADIO_POWER_KEY_N_I(keys_n[2]), .RTC_ALARM_I(alarm), .RTC_HOUR_I(hour),
    .RTC_WEEKDAY_I(wday), .RX_VALID_I(rx_v), .RX_CMD_I(rx_c), .RX_DATA_I(rx_d),
    .RX_READY_O(rx_r), .TX_VALID_O(tx_v), .TX_READY_I(tx_r), .TX_MSG_O(tx_m),
    .TX_DATA_O(tx_d), .ADC_START_O(), .ADC_DONE_I(adc_done), .ADC_DATA_I(adc_mv),
    .BATT_DIV_EN_O(), .BATT_LOW_O(), .BUZZER_TONE_OUT_O(), .MOTOR_O(), .CELL_LAMP_O(),
    .DISPLAY_ON_O(), .IDLE_O(), .RADIO_SUPPLY_SWITCH_O(), .RADIO_RESET_O(),
    .ALARM_WRITE_O(), .ALARM_MINUTE_VALUE_O(), .ALARM_HOUR_VALUE_O(),
    .ALARM_WEEKDAY_VALUE_O(), .CAL_WRITE_O(), .CAL_COUNTS_O());

  prc_radio_model radio (.clk_i(clk), .slow_i(slow), .rx_ready_i(rx_r), .rx_valid_o(rx_v),
    .rx_cmd_o(rx_c), .rx_data_o(rx_d), .tx_valid_i(tx_v), .tx_msg_i(tx_m),
    .tx_data_i(tx_d), .tx_ready_o(tx_r));

  // Converter answers three cycles after each start
  always @(negedge clk)
  begin
    adc_done = (adc_cnt == 1);
    if (uut.ADC_START_O === 1'b1) adc_cnt = 3;
    else if (adc_cnt > 0) adc_cnt--;
  end

  task automatic check(input string what, input logic [55:0] exp, got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic cmd(input logic [7:0] c, input logic [55:0] d);
    radio.send(c, d, n);
    if (n < 400) return;
    errors++;
    $display("BAD send %h expected taken seen timeout", c);
    test_done();
  endtask : cmd

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  function automatic logic pick(input int s);
    case (s)
      0: return uut.IDLE_O;
      1: return uut.MOTOR_O;
      2: return uut.BATT_DIV_EN_O;
      3: return uut.BUZZER_TONE_OUT_O;
      default: return radio.msg_count != mc;
    endcase
  endfunction : pick

  task automatic wait_for(input int s, input logic v, input int lim, output int w);
    for (w = 0; w < lim; w++)
    begin
      @(negedge clk);
      if (pick(s) === v) return;
    end
    errors++;
    $display("BAD wait %0d expected %b seen timeout", s, v);
    test_done();
  endtask : wait_for

  task automatic press(input int k);
    keys_n[k] = 1'b0;
    repeat (6) @(negedge clk);
    keys_n[k] = 1'b1;
    repeat (6) @(negedge clk);
  endtask : press

  task automatic pulse(input logic h);
    alarm = !h;
    hour = h;
    @(negedge clk);
    alarm = 1'b0;
    hour = 1'b0;
  endtask : pulse

  initial
  begin
    repeat (20) @(negedge clk);
    check("reset outs", 56'h7, {uut.DISPLAY_ON_O, uut.RADIO_SUPPLY_SWITCH_O,
      uut.RADIO_RESET_O});
    srst = 1'b0;
    wait_for(2, 1'b1, 20, n);
    wait_for(2, 1'b0, 20, n);
    check("batt low", 56'h0, uut.BATT_LOW_O);
    cmd(CMD_SET_ALARM, 56'h04_0715);
    repeat (3) @(negedge clk);
    check("alarm", 56'h040715, {uut.ALARM_WEEKDAY_VALUE_O, uut.ALARM_HOUR_VALUE_O,
      uut.ALARM_MINUTE_VALUE_O});
    cmd(CMD_RTC_CAL, 56'h180b031c172d09);
    repeat (3) @(negedge clk);
    check("cal", 56'h180b031c172d09, uut.CAL_COUNTS_O);
    slow = 1'b1;
    mc = radio.msg_count;
    cmd(CMD_BATT_QUERY, 56'h0);
    wait_for(5, 1'b1, 60, n);
    check("query", {MSG_BATT_VALUE, 16'h0bb8}, {radio.last_msg, radio.last_data});
    mc = radio.msg_count;
    press(1);
    wait_for(5, 1'b1, 60, n);
    check("cfg msg", MSG_RADIO_CFG, radio.last_msg);
    press(2);
    check("supply off", 56'h0, uut.RADIO_SUPPLY_SWITCH_O);
    press(2);
    check("supply on", 56'h1, uut.RADIO_SUPPLY_SWITCH_O);
    for (i = 0; i < 7; i++)
    begin
      wday = 3'(i);
      pulse(1'b0);
      wait_for(1, 1'b1, 40, n);
      t = 0;
      prev = uut.BUZZER_TONE_OUT_O;
      repeat (32)
      begin
        @(negedge clk);
        t += int'(uut.BUZZER_TONE_OUT_O && !prev);
        prev = uut.BUZZER_TONE_OUT_O;
      end
      check("tone rises", 56'h4, 56'(t));
      check("lamp", 56'h1 << i, uut.CELL_LAMP_O);
      mc = radio.msg_count;
      press(0);
      check("alarm off", 56'h0, {uut.MOTOR_O, uut.CELL_LAMP_O});
      wait_for(5, 1'b1, 60, n);
      check("pill msg", MSG_PILL_TAKEN, radio.last_msg);
    end
    mc = radio.msg_count;
    pulse(1'b0);
    wait_for(1, 1'b1, 40, n);
    wait_for(1, 1'b0, 1300, n);
    check("window", 56'h1, 56'(n > 1150 && n < 1260));
    check("no pill", 56'(mc), 56'(radio.msg_count));
    wait_for(0, 1'b1, 260, n);
    check("idle time", 56'h1, 56'(n >= 180));
    press(0);
    check("woken", 56'h1, {uut.IDLE_O, uut.DISPLAY_ON_O});
    wait_for(0, 1'b1, 260, n);
    adc_mv = 16'h0960;
    pulse(1'b1);
    wait_for(2, 1'b1, 20, n);
    wait_for(2, 1'b0, 20, n);
    check("batt low", 56'h1, uut.BATT_LOW_O);
    wait_for(3, 1'b1, 1300, n);
    adc_mv = 16'h0bb8;
    pulse(1'b1);
    wait_for(2, 1'b1, 20, n);
    wait_for(2, 1'b0, 20, n);
    check("batt ok", 56'h0, uut.BATT_LOW_O);
    for (i = 2; i < 259; i++)
    begin
      cmd(CMD_SET_ALARM, 56'(i));
      if (n > 200) break;
    end
    check("adjust at", 56'd257, 56'(i));
    check("copied", 56'h100, uut.u_store.mem[10'h102]);
    check("erased", 56'h0, uut.u_store.mem[10'h0ff]);
    test_done();
  end
endmodule : prc_top_tb_top

bind prc_top prc_top_properties chk (.*);
